/* File: rtl/tgfstv_pkg.sv */
// constants for the throttle, input, fan status and temperature value bank
package tgfstv_pkg;
  // ***********************************************************
  // register offsets
  // ***********************************************************
  localparam logic [7:0] OFS_PROC1_THROTTLE = 8'h4c;
  localparam logic [7:0] OFS_PROC2_THROTTLE = 8'h4d;
  localparam logic [7:0] OFS_GENERAL_INPUT = 8'h4e;
  localparam logic [7:0] OFS_FAN_LIMIT = 8'h4f;
  localparam logic [7:0] OFS_ZONE1_TEMP = 8'h50;
  localparam logic [7:0] OFS_ZONE2_TEMP = 8'h51;
  localparam logic [7:0] OFS_ZONE3_TEMP = 8'h52;
  localparam logic [7:0] OFS_ZONE4_TEMP = 8'h53;

  // ***********************************************************
  // reset values and fixed codes
  // ***********************************************************
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] ZONE4_RESET = 8'h00;
  localparam logic [7:0] TEMP_RESET = 8'h00;
  localparam logic [7:0] DIODE_FAULT_CODE = 8'h80;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // ***********************************************************
  // throttle status field positions, plus the fourth fan bit
  // ***********************************************************
  localparam int BIT_ANY_THROTTLE = 0;
  localparam int BIT_UNDER_EIGHTH = 1;
  localparam int BIT_TO_QUARTER = 2;
  localparam int BIT_TO_HALF = 3;
  localparam int BIT_TO_THREE_QUARTER = 4;
  localparam int BIT_BELOW_FULL = 5;
  localparam int BIT_FULL_THROTTLE = 6;
  localparam int BIT_LIMIT_EXCEEDED = 7;
  localparam int BIT_FOURTH_FAN = 3;

  // ***********************************************************
  // measurement in 1/256 of the interval
  // ***********************************************************
  localparam logic [8:0] CNT_EIGHTH = 9'h020;
  localparam logic [8:0] CNT_QUARTER = 9'h040;
  localparam logic [8:0] CNT_HALF = 9'h080;
  localparam logic [8:0] CNT_THREE_QUARTER = 9'h0c0;
  localparam logic [8:0] CNT_FULL = 9'h100;
  localparam logic [7:0] LAST_SLOT = 8'hff;
  localparam int TICK_CYCLES = 4;

  typedef enum logic [1:0] {
    TGFSTV_S0 = 2'b00,
    TGFSTV_S1 = 2'b01,
    TGFSTV_S3 = 2'b10,
    TGFSTV_S45 = 2'b11
  } tgfstv_sleep_t;
endpackage

/* File: rtl/tgfstv_throttle_meter.sv */
// measures the active fraction of one processor-hot input per interval
`timescale 1ns/1ns
`default_nettype none
module tgfstv_throttle_meter #(
  parameter int TICK_CYCLES = tgfstv_pkg::TICK_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic hot_active,
  output logic meas_valid_q,
  output logic [8:0] meas_count_q
);
  localparam int TW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

  logic [TW-1:0] tick_q;
  logic [7:0] slot_q;
  logic [8:0] acc_q;
  logic tick;

  assign tick = (tick_q == TICK_LAST);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tick_q <= '0;
    end else if (tick) begin
      tick_q <= '0;
    end else begin
      tick_q <= tick_q + TW'(1);
    end
  end

  // 256 samples per interval, so the count is already in 1/256 units
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      slot_q <= 8'h00;
      acc_q <= 9'h000;
      meas_valid_q <= 1'b0;
      meas_count_q <= 9'h000;
    end else begin
      meas_valid_q <= 1'b0;
      if (tick) begin
        slot_q <= slot_q + 8'h01;
        if (slot_q == tgfstv_pkg::LAST_SLOT) begin
          meas_valid_q <= 1'b1; // see R14
          meas_count_q <= acc_q + {8'h00, hot_active};
          acc_q <= 9'h000;
        end else begin
          acc_q <= acc_q + {8'h00, hot_active};
        end
      end
    end
  end

  a_count_range: assert property (@(posedge clk) disable iff (sys_rst) // see R14
    meas_valid_q |-> meas_count_q <= tgfstv_pkg::CNT_FULL)
    else $error("throttle measurement above full scale");
endmodule
`default_nettype wire

/* File: rtl/tgfstv_top.sv */
// status and value register bank: throttle bands, general inputs, fans, zone temperatures
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// R1: throttle bit 0 sets whenever a measurement shows any throttling above zero.
// R2: bit 1 for 0 to under 12.5 percent, bit 2 for 12.5 to 25.
// R3: bit 3 for 25 to 50, bit 4 for 50 to 75, bit 5 for 75 to 100.
// R4: bit 6 sets only when hot was active the whole interval.
// R5: bit 7 sets when throttling exceeds that processor's programmed limit.
// R6: only bit 7 of each throttle register feeds the host error flag.
// R7: second processor has an identical throttle register at 4Dh.
// R8: general input bit n sets while pin n is low, unless masked.
// R9: fan bits 0 to 2 set when tach count exceeds the fan limit.
// R10: fan bit 3 is read-only, bits 7:4 read as zero.
// R11: zones 1 to 3 are updated by the block, read-only to software.
// R12: zone 4 is written by the external master, stored as read/write.
// R13: zones 1 and 2 read 80h when the remote diode is faulty.
// R14: throttling is measured per interval as an active fraction in 1/256 units.
// R15: status bits stay set until software writes one to clear them; fan bit 3 is not sticky and follows its tach comparison.
// R16: status bits are not set in the sleep states that mask them.
module tgfstv_top #(
  parameter int TACH_W = 16,
  parameter int TICK_CYCLES = tgfstv_pkg::TICK_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata_q,
  input wire logic cpu_a_hot_input_n,
  input wire logic cpu_b_hot_input_n,
  input wire logic [7:0] cpu_a_limit,
  input wire logic [7:0] cpu_b_limit,
  input wire logic [7:0] general_purpose_pin,
  input wire logic [7:0] general_input_mask,
  input wire logic [3:0][TACH_W-1:0] fan_tach_count,
  input wire logic [3:0][TACH_W-1:0] fan_tach_limit,
  input wire logic [1:0] sleep_state,
  input wire logic [7:0] zone1_sensor_value,
  input wire logic [7:0] zone2_sensor_value,
  input wire logic [7:0] zone3_sensor_value,
  input wire logic remote_diode1_fault,
  input wire logic remote_diode2_fault,
  output logic throttle_host_err
);
  // ***********************************************************
  // pin synchronisers
  // ***********************************************************
  logic [9:0] pin_meta_q;
  logic [9:0] pin_sync_q;

  // first stage is read by the second stage only
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_meta_q <= 10'h3ff;
      pin_sync_q <= 10'h3ff;
    end else begin
      pin_meta_q <= {general_purpose_pin, cpu_b_hot_input_n, cpu_a_hot_input_n};
      pin_sync_q <= pin_meta_q;
    end
  end

  // ***********************************************************
  // sleep masking
  // ***********************************************************
  logic throttle_masked;
  logic input_fan_masked;

  // throttle bits are masked in S3 and S4/5, inputs and fan bits 0 to 2 also in S1
  assign throttle_masked = (sleep_state == tgfstv_pkg::TGFSTV_S3) ||
                           (sleep_state == tgfstv_pkg::TGFSTV_S45); // see R16
  assign input_fan_masked = (sleep_state != tgfstv_pkg::TGFSTV_S0); // see R16

  // ***********************************************************
  // throttle measurement and status
  // ***********************************************************
  function automatic logic [7:0] throttle_bands(input logic [8:0] n, input logic [7:0] lim);
    logic [7:0] b;
    b = 8'h00;
    b[tgfstv_pkg::BIT_ANY_THROTTLE] = (n != 9'h000); // see R1
    b[tgfstv_pkg::BIT_UNDER_EIGHTH] = (n < tgfstv_pkg::CNT_EIGHTH); // see R2
    b[tgfstv_pkg::BIT_TO_QUARTER] = (n >= tgfstv_pkg::CNT_EIGHTH) &&
                                    (n < tgfstv_pkg::CNT_QUARTER); // see R2
    b[tgfstv_pkg::BIT_TO_HALF] = (n >= tgfstv_pkg::CNT_QUARTER) &&
                                 (n < tgfstv_pkg::CNT_HALF); // see R3
    b[tgfstv_pkg::BIT_TO_THREE_QUARTER] = (n >= tgfstv_pkg::CNT_HALF) &&
                                          (n < tgfstv_pkg::CNT_THREE_QUARTER); // see R3
    b[tgfstv_pkg::BIT_BELOW_FULL] = (n >= tgfstv_pkg::CNT_THREE_QUARTER) &&
                                    (n < tgfstv_pkg::CNT_FULL); // see R3
    b[tgfstv_pkg::BIT_FULL_THROTTLE] = (n == tgfstv_pkg::CNT_FULL); // see R4
    b[tgfstv_pkg::BIT_LIMIT_EXCEEDED] = (n > {1'b0, lim}); // see R5
    return b;
  endfunction

  function automatic logic [7:0] clear_bits(input logic wr, input logic [7:0] addr,
                                            input logic [7:0] ofs, input logic [7:0] data);
    return (wr && (addr == ofs)) ? data : 8'h00;
  endfunction

  logic [1:0] meas_valid;
  logic [1:0][8:0] meas_count;
  logic [1:0][7:0] thr_limit;
  logic [1:0][7:0] thr_ofs;
  logic [1:0][7:0] thr_set;
  logic [1:0][7:0] thr_clr;
  logic [1:0][7:0] thr_q;

  assign thr_limit[0] = cpu_a_limit;
  assign thr_limit[1] = cpu_b_limit;
  assign thr_ofs[0] = tgfstv_pkg::OFS_PROC1_THROTTLE;
  assign thr_ofs[1] = tgfstv_pkg::OFS_PROC2_THROTTLE; // see R7

  for (genvar p = 0; p < 2; p++) begin : g_proc
    tgfstv_throttle_meter #(
      .TICK_CYCLES(TICK_CYCLES)
    ) u_meter (
      .clk(clk),
      .sys_rst(sys_rst),
      .hot_active(~pin_sync_q[p]),
      .meas_valid_q(meas_valid[p]),
      .meas_count_q(meas_count[p])
    );

    assign thr_set[p] = (meas_valid[p] && !throttle_masked) ?
                        throttle_bands(meas_count[p], thr_limit[p]) : 8'h00;
    assign thr_clr[p] = clear_bits(reg_wr, reg_addr, thr_ofs[p], reg_wdata);

    // a set in the clearing cycle survives the clear
    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        thr_q[p] <= tgfstv_pkg::STATUS_RESET;
      end else begin
        thr_q[p] <= (thr_q[p] & ~thr_clr[p]) | thr_set[p]; // see R15, R7
      end
    end
  end

  assign throttle_host_err = thr_q[0][tgfstv_pkg::BIT_LIMIT_EXCEEDED] |
                             thr_q[1][tgfstv_pkg::BIT_LIMIT_EXCEEDED]; // see R6

  // ***********************************************************
  // general inputs and fans
  // ***********************************************************
  logic [7:0] gpi_set;
  logic [7:0] gpi_clr;
  logic [7:0] gpi_q;
  logic [2:0] fan_set;
  logic [7:0] fan_clr_all;
  logic [2:0] fan_clr;
  logic [2:0] fan_q;
  logic [3:0] fan_over;
  logic fourth_fan_tach_flag_q;

  assign gpi_set = input_fan_masked ? 8'h00 :
                   (~pin_sync_q[9:2] & ~general_input_mask); // see R8
  assign gpi_clr = clear_bits(reg_wr, reg_addr, tgfstv_pkg::OFS_GENERAL_INPUT, reg_wdata);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      gpi_q <= tgfstv_pkg::STATUS_RESET;
    end else begin
      gpi_q <= (gpi_q & ~gpi_clr) | gpi_set; // see R15
    end
  end

  for (genvar f = 0; f < 4; f++) begin : g_fan
    assign fan_over[f] = (fan_tach_count[f] > fan_tach_limit[f]); // see R9
  end

  assign fan_set = input_fan_masked ? 3'h0 : fan_over[2:0]; // see R9
  assign fan_clr_all = clear_bits(reg_wr, reg_addr, tgfstv_pkg::OFS_FAN_LIMIT, reg_wdata);
  // only the three sticky fan bits take a clear; bit 3 and up are not writable
  assign fan_clr = fan_clr_all[2:0];

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fan_q <= 3'h0;
      fourth_fan_tach_flag_q <= 1'b0;
    end else begin
      fan_q <= (fan_q & ~fan_clr) | fan_set; // see R15
      // the fourth fan bit follows the comparison and ignores writes
      fourth_fan_tach_flag_q <= fan_over[3]; // see R10
    end
  end

  // ***********************************************************
  // zone temperatures
  // ***********************************************************
  logic [7:0] zone1_q;
  logic [7:0] zone2_q;
  logic [7:0] zone3_q;
  logic [7:0] zone4_q;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      zone1_q <= tgfstv_pkg::TEMP_RESET;
      zone2_q <= tgfstv_pkg::TEMP_RESET;
      zone3_q <= tgfstv_pkg::TEMP_RESET;
    end else begin
      zone1_q <= remote_diode1_fault ? tgfstv_pkg::DIODE_FAULT_CODE :
                 zone1_sensor_value; // see R11, R13
      zone2_q <= remote_diode2_fault ? tgfstv_pkg::DIODE_FAULT_CODE :
                 zone2_sensor_value; // see R11, R13
      zone3_q <= zone3_sensor_value; // see R11
    end
  end

  // only the external master changes zone 4
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      zone4_q <= tgfstv_pkg::ZONE4_RESET;
    end else if (reg_wr && (reg_addr == tgfstv_pkg::OFS_ZONE4_TEMP)) begin
      zone4_q <= reg_wdata; // see R12
    end
  end

  // ***********************************************************
  // read path
  // ***********************************************************
  logic [7:0] read_mux;

  always_comb begin
    unique case (reg_addr)
      tgfstv_pkg::OFS_PROC1_THROTTLE: read_mux = thr_q[0];
      tgfstv_pkg::OFS_PROC2_THROTTLE: read_mux = thr_q[1];
      tgfstv_pkg::OFS_GENERAL_INPUT: read_mux = gpi_q;
      tgfstv_pkg::OFS_FAN_LIMIT: read_mux = {4'h0, fourth_fan_tach_flag_q, fan_q}; // see R10
      tgfstv_pkg::OFS_ZONE1_TEMP: read_mux = zone1_q;
      tgfstv_pkg::OFS_ZONE2_TEMP: read_mux = zone2_q;
      tgfstv_pkg::OFS_ZONE3_TEMP: read_mux = zone3_q;
      tgfstv_pkg::OFS_ZONE4_TEMP: read_mux = zone4_q;
      default: read_mux = tgfstv_pkg::UNMAPPED_READ;
    endcase
  end

  // read data lags the address by one clock
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata_q <= tgfstv_pkg::UNMAPPED_READ;
    end else begin
      reg_rdata_q <= read_mux;
    end
  end

  // ***********************************************************
  // assertions
  // ***********************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_meas_a_unmasked;
    meas_valid[0] && !throttle_masked;
  endsequence

  a_any_band: assert property ( // see R1
    s_meas_a_unmasked and (meas_count[0] != 9'h000) |=> thr_q[0][0])
    else $error("any-throttle bit not set");

  a_low_band: assert property ( // see R2
    s_meas_a_unmasked and (meas_count[0] < 9'h020) |=> thr_q[0][1])
    else $error("under-eighth band bit not set");

  a_mid_band: assert property ( // see R3
    s_meas_a_unmasked and (meas_count[0] >= 9'h080) and (meas_count[0] < 9'h0c0)
    |=> thr_q[0][4])
    else $error("half to three-quarter band bit not set");

  a_full_only: assert property ( // see R4
    $rose(thr_q[1][6]) |-> $past(meas_valid[1] && meas_count[1] == 9'h100))
    else $error("full-throttle bit set without full interval");

  a_limit_bit: assert property ( // see R5
    meas_valid[1] && !throttle_masked && (meas_count[1] > {1'b0, cpu_b_limit})
    |=> thr_q[1][7] && throttle_host_err)
    else $error("limit bit or host flag missing");

  a_host_flag: assert property ( // see R6
    (thr_q[0][7] == 1'b0) && (thr_q[1][7] == 1'b0) |-> !throttle_host_err)
    else $error("band bits reached host flag");

  a_gpi_low: assert property ( // see R8
    !pin_sync_q[2] && !general_input_mask[0] && (sleep_state == 2'b00) |=> gpi_q[0])
    else $error("general input low not flagged");

  a_fan_readonly: assert property ( // see R10
    reg_wr && (reg_addr == 8'h4f) && reg_wdata[3] && fan_over[3] |=> fourth_fan_tach_flag_q)
    else $error("fourth fan bit cleared by write");

  a_diode_code: assert property ( // see R13
    remote_diode1_fault |=> ##1 (reg_rdata_q == 8'h80) || $past(reg_addr) != 8'h50)
    else $error("zone 1 did not read fault code");

  a_sticky_gpi: assert property ( // see R15
    gpi_q[7] && !(reg_wr && reg_addr == 8'h4e && reg_wdata[7]) |=> gpi_q[7])
    else $error("general input flag dropped without clear");

  a_sleep_mask: assert property ( // see R16
    (sleep_state == 2'b10) && (thr_q[0] == 8'h00) |=> (thr_q[0] == 8'h00))
    else $error("throttle bit set while asleep");
endmodule
`default_nettype wire

/* File: dv/tgfstv_host_model.sv */
// host model that reaches the bank through its byte-wide register port
`timescale 1ns/1ns
`default_nettype none
module tgfstv_host_model (
  input wire logic clk,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata_q
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
  end

  // ***********************************************************
  // access tasks, driven on the falling edge
  // ***********************************************************
  // zone 4 is only ever filled by this master
  task automatic wr(input logic [7:0] ofs, input logic [7:0] data);
    @(negedge clk);
    reg_addr = ofs;
    reg_wdata = data;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    // idle data never repeats the last byte, so a stale capture shows up
    reg_wdata = ~data;
  endtask

  task automatic rd(input logic [7:0] ofs, output logic [7:0] data);
    @(negedge clk);
    reg_addr = ofs;
    @(negedge clk);
    data = reg_rdata_q;
  endtask
endmodule
`default_nettype wire

/* File: dv/tgfstv_top_tb_top.sv */
// self-checking bench for the throttle, input, fan and temperature bank
`timescale 1ns/1ns
`default_nettype none
module tgfstv_top_tb_top;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr, reg_wdata, reg_rdata_q, rd_val, ea, eb;
  logic reg_wr, host_err;
  logic hot_n = 1'b1;
  logic [7:0] lim_a = 8'h7f;
  logic [7:0] lim_b = 8'hc0;
  logic [7:0] gp_pin = 8'hff;
  logic [7:0] gp_mask = 8'h00;
  logic [3:0][15:0] tach_cnt = {4{16'h0010}};
  logic [3:0][15:0] tach_lim = {4{16'h0100}};
  logic [1:0] sleep = 2'h0;
  logic [7:0] z1 = 8'h2a;
  logic [7:0] z2 = 8'h3b;
  logic [7:0] z3 = 8'h4c;
  logic flt1 = 1'b0;
  logic flt2 = 1'b0;
  logic [2:0] ph = 3'h0;
  logic [3:0] duty = 4'h0;
  logic [3:0] dlist [8] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h6, 4'h7, 4'h8, 4'h8};
  int n_mismatch = 0;
  int samples_checked = 0;
  int cycles = 0;

  always #2 clk = ~clk;

  tgfstv_host_model host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q));

  tgfstv_top #(.TACH_W(16), .TICK_CYCLES(1)) dut (.clk(clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
    .cpu_a_hot_input_n(hot_n), .cpu_b_hot_input_n(hot_n), .cpu_a_limit(lim_a),
    .cpu_b_limit(lim_b), .general_purpose_pin(gp_pin), .general_input_mask(gp_mask),
    .fan_tach_count(tach_cnt), .fan_tach_limit(tach_lim), .sleep_state(sleep),
    .zone1_sensor_value(z1), .zone2_sensor_value(z2), .zone3_sensor_value(z3),
    .remote_diode1_fault(flt1), .remote_diode2_fault(flt2), .throttle_host_err(host_err));

  // ***********************************************************
  // stimulus helpers
  // ***********************************************************
  // period-8 pattern: the count per 256-slot interval is exact whatever the phase
  always @(negedge clk) begin
    ph <= ph + 3'h1;
    hot_n <= ({1'b0, ph} >= duty);
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      summarize();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rdchk(input logic [7:0] ofs, input logic [7:0] exp);
    host.rd(ofs, rd_val);
    chk(rd_val, exp);
  endtask

  function automatic logic [7:0] band(input logic [3:0] d, input logic [7:0] lim);
    logic [8:0] c;
    logic [7:0] b;
    c = {d, 5'h00};
    b[0] = (c != 9'h000);
    b[1] = (c < tgfstv_pkg::CNT_EIGHTH);
    b[2] = (c >= tgfstv_pkg::CNT_EIGHTH) && (c < tgfstv_pkg::CNT_QUARTER);
    b[3] = (c >= tgfstv_pkg::CNT_QUARTER) && (c < tgfstv_pkg::CNT_HALF);
    b[4] = (c >= tgfstv_pkg::CNT_HALF) && (c < tgfstv_pkg::CNT_THREE_QUARTER);
    b[5] = (c >= tgfstv_pkg::CNT_THREE_QUARTER) && (c < tgfstv_pkg::CNT_FULL);
    b[6] = (c == tgfstv_pkg::CNT_FULL);
    b[7] = (c > {1'b0, lim});
    return b;
  endfunction

  task summarize;
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ***********************************************************
  // main sequence
  // ***********************************************************
  initial begin
    repeat (3) @(negedge clk);
    sys_rst = 1'b0;
    rdchk(tgfstv_pkg::OFS_PROC1_THROTTLE, 8'h00);
    rdchk(tgfstv_pkg::OFS_PROC2_THROTTLE, 8'h00);
    rdchk(tgfstv_pkg::OFS_GENERAL_INPUT, 8'h00);
    rdchk(tgfstv_pkg::OFS_FAN_LIMIT, 8'h00);
    rdchk(tgfstv_pkg::OFS_ZONE4_TEMP, 8'h00);
    // zones follow their sensors; writes there and to holes are dropped
    host.wr(tgfstv_pkg::OFS_ZONE1_TEMP, 8'h11);
    host.wr(8'h60, 8'h77);
    rdchk(tgfstv_pkg::OFS_ZONE1_TEMP, 8'h2a);
    rdchk(tgfstv_pkg::OFS_ZONE2_TEMP, 8'h3b);
    rdchk(8'h60, 8'h00);
    flt1 = 1'b1;
    flt2 = 1'b1;
    z3 = 8'h4d;
    repeat (3) @(negedge clk);
    rdchk(tgfstv_pkg::OFS_ZONE1_TEMP, 8'h80);
    rdchk(tgfstv_pkg::OFS_ZONE2_TEMP, 8'h80);
    rdchk(tgfstv_pkg::OFS_ZONE3_TEMP, 8'h4d);
    host.wr(tgfstv_pkg::OFS_ZONE4_TEMP, 8'h5a);
    rdchk(tgfstv_pkg::OFS_ZONE4_TEMP, 8'h5a);
    // general inputs: sticky, masked per bit, selective clear, quiet in S1
    gp_mask = 8'h20;
    gp_pin = 8'h97;
    repeat (8) @(negedge clk);
    gp_pin = 8'hff;
    repeat (8) @(negedge clk);
    rdchk(tgfstv_pkg::OFS_GENERAL_INPUT, 8'h48);
    host.wr(tgfstv_pkg::OFS_GENERAL_INPUT, 8'h08);
    rdchk(tgfstv_pkg::OFS_GENERAL_INPUT, 8'h40);
    sleep = 2'h1;
    gp_pin = 8'hfe;
    repeat (8) @(negedge clk);
    gp_pin = 8'hff;
    repeat (8) @(negedge clk);
    sleep = 2'h0;
    rdchk(tgfstv_pkg::OFS_GENERAL_INPUT, 8'h40);
    // fans: equal count is not above; fan 4 is a live read-only flag
    tach_cnt[0] = 16'h0100;
    tach_cnt[1] = 16'h0200;
    tach_cnt[2] = 16'h0101;
    tach_cnt[3] = 16'h0200;
    repeat (4) @(negedge clk);
    tach_cnt[1] = 16'h0010;
    tach_cnt[2] = 16'h0010;
    rdchk(tgfstv_pkg::OFS_FAN_LIMIT, 8'h0e);
    host.wr(tgfstv_pkg::OFS_FAN_LIMIT, 8'hff);
    rdchk(tgfstv_pkg::OFS_FAN_LIMIT, 8'h08);
    tach_cnt[3] = 16'h0010;
    repeat (4) @(negedge clk);
    rdchk(tgfstv_pkg::OFS_FAN_LIMIT, 8'h00);
    // throttle bands for each duty; the last pass sits in S3
    for (int i = 0; i < 8; i++) begin
      duty = dlist[i];
      sleep = (i == 7) ? 2'h2 : 2'h0;
      repeat (600) @(negedge clk);
      host.wr(tgfstv_pkg::OFS_PROC1_THROTTLE, 8'hff);
      host.wr(tgfstv_pkg::OFS_PROC2_THROTTLE, 8'hff);
      repeat (600) @(negedge clk);
      ea = (i == 7) ? 8'h00 : band(duty, lim_a);
      eb = (i == 7) ? 8'h00 : band(duty, lim_b);
      rdchk(tgfstv_pkg::OFS_PROC1_THROTTLE, ea);
      rdchk(tgfstv_pkg::OFS_PROC2_THROTTLE, eb);
      chk({7'h00, host_err}, {7'h00, ea[7] | eb[7]});
    end
    summarize();
  end
endmodule
`default_nettype wire
